// file: core/irq_status.sv
// Purpose: Sticky event status, mask and one level interrupt
// Assumes: Write strobes are one-cycle pulses
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
module irq_status
#(
	parameter int W = 5
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Events and software access
	input wire logic [W-1:0] events,
	input wire logic clrWr,
	input wire logic maskWr,
	input wire logic [W-1:0] wrData,
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			status <= '0;
		else if (clkEn)
			status <= events | (status & ~(clrWr ? wrData : '0));
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			mask <= '0;
		else if (clkEn && maskWr)
			mask <= wrData;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			irq <= 1'b0;
		else if (clkEn)
			irq <= |(status & mask);
	end
endmodule

// file: core/persist_counter.sv
// Purpose: Counts low-speed ticks while a condition stands
// Assumes: tick is a one-cycle pulse in the clk domain
// Notes: done pulses once per episode of the condition
`timescale 1ns/1ps
module persist_counter
	import rst_cause_pkg::*;
#(
	parameter int LIMIT = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// Condition
	input wire logic tick,
	input wire logic active,
	output logic done
);
	localparam int CW = $clog2(LIMIT + 1);
	localparam logic [CW-1:0] LIM = CW'(LIMIT);
	logic [CW-1:0] cnt_r;
	logic fired_r;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			cnt_r <= '0;
		else if (clkEn)
		begin
			if (!active)
				cnt_r <= '0;
			else if (tick && cnt_r != LIM)
				cnt_r <= cnt_r + CW'(1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			fired_r <= 1'b0;
		else if (clkEn)
			fired_r <= active && (fired_r || cnt_r == LIM);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			done <= 1'b0;
		else if (clkEn)
			done <= active && cnt_r == LIM && !fired_r;
	end
endmodule

// file: core/reset_source_and_flag_control.sv
// Purpose: Reset sources, cause flags and time-out/power-down status
// Assumes: All inputs synchronous to clk; lircTick from the slow clock
// Notes: APB slave with one wait state
// How it works
// - Code 5A selects 2.1V, A5 disables detection
// - Undefined select code resets after delay
// - Select corruption reset restores code 5A
// - Persistent low voltage resets, select kept
// - Flag bits 7 to 3 read zero
// - Low-voltage flag sticky, software clears
// - Select-corrupt flag set while code undefined
// - Running time-out resets select and watchdog codes, sets time-out
// - Sleeping time-out clears only PC and SP
// - Time-out/power-down flags per reset type
// - Power-on initialises interrupts, watchdog, pins
// - Watchdog code corruption flag sticky
// - Low-voltage detection off in idle/sleep
// - Watchdog code: off, on, else reset
//
// Chosen here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module reset_source_and_flag_control
	import rst_cause_pkg::*;
#(
	parameter int SW_TICKS = SW_RESET_TICKS,
	parameter int LV_TICKS = LV_PERSIST_TICKS,
	parameter int HOLD_CYCLES = RST_HOLD_CYCLES
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic clkEn,
	// APB slave
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Reset sources
	input wire logic lircTick,
	input wire logic lowVoltage,
	input wire logic wdogTimeout,
	input wire logic [1:0] powerMode,
	input wire logic haltEntry,
	input wire logic clrWdtInsn,
	// Reset and control outputs
	output logic coreResetReq,
	output logic wdogRestart,
	output logic pcSpClear,
	output logic lvDetectEnable,
	output logic wdogEnable,
	output logic [2:0] wdogPeriodSel,
	output logic timeoutStatusFlag,
	output logic powerdownStatusFlag,
	output logic irq
);
	// ****************************************************************
	// Declarations
	// ****************************************************************
	typedef enum logic [0:0] {ST_RUN, ST_HOLD} state_e;
	localparam int HW = $clog2(HOLD_CYCLES + 1);
	localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);

	state_e state_r;
	state_e state_nxt;
	logic [HW-1:0] holdCnt_r;
	logic [7:0] selCode_r;
	logic [7:0] wdogCtrl_r;
	logic [FLAG_W-1:0] flags_r;
	logic [FLAG_W-1:0] flags_nxt;
	logic [FLAG_W-1:0] flagSet;
	logic [IRQ_W-1:0] irqEvents;
	logic [IRQ_W-1:0] irqStat;
	logic [IRQ_W-1:0] irqMask;
	logic [31:0] rdData;
	logic sleepy;
	logic running;
	logic selCorrupt;
	logic wdogCorrupt;
	logic lvActive;
	logic lvDone;
	logic selDone;
	logic wdDone;
	logic toRun;
	logic toSleep;
	logic fullReq;
	logic access;
	logic wrEn;
	logic mapped;
	logic [4:0] wdogCode;

	// ****************************************************************
	// Source qualification
	// ****************************************************************
	assign sleepy = powerMode == MODE_IDLE || powerMode == MODE_SLEEP;
	assign running = state_r == ST_RUN;
	assign wdogCode = wdogCtrl_r[WDOG_CODE_LSB +: 5];
	assign selCorrupt = selCode_r != SEL_CODE_21V
		&& selCode_r != SEL_CODE_OFF;
	assign wdogCorrupt = wdogCode != WDOG_CODE_ON
		&& wdogCode != WDOG_CODE_OFF;
	assign lvActive = lowVoltage && selCode_r == SEL_CODE_21V
		&& !sleepy && running;
	assign toRun = wdogTimeout && !sleepy && running;
	assign toSleep = wdogTimeout && sleepy && running;
	assign fullReq = lvDone || selDone || wdDone || toRun;

	// ****************************************************************
	// Delay counters on the slow oscillator
	// ****************************************************************
	persist_counter #(
		.LIMIT(LV_TICKS + 1)
	) lvQual (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.tick(lircTick),
		.active(lvActive),
		.done(lvDone)
	);

	persist_counter #(
		.LIMIT(SW_TICKS)
	) selDelay (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.tick(lircTick),
		.active(selCorrupt && running),
		.done(selDone)
	);

	persist_counter #(
		.LIMIT(SW_TICKS)
	) wdDelay (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.tick(lircTick),
		.active(wdogCorrupt && running),
		.done(wdDone)
	);

	// ****************************************************************
	// Reset sequencer
	// ****************************************************************
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN:
			begin
				if (fullReq)
					state_nxt = ST_HOLD;
			end
			ST_HOLD:
			begin
				if (holdCnt_r == HOLD_LAST)
					state_nxt = ST_RUN;
			end
			default:
				state_nxt = ST_HOLD;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			state_r <= ST_HOLD;
		else if (clkEn)
			state_r <= state_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			holdCnt_r <= '0;
		else if (clkEn)
		begin
			if (state_r == ST_HOLD)
				holdCnt_r <= holdCnt_r + HW'(1);
			else
				holdCnt_r <= '0;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			coreResetReq <= 1'b1;
		else if (clkEn)
			coreResetReq <= state_nxt == ST_HOLD;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wdogRestart <= 1'b0;
		else if (clkEn)
			wdogRestart <= state_r == ST_HOLD
				&& state_nxt == ST_RUN;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pcSpClear <= 1'b0;
		else if (clkEn)
			pcSpClear <= toSleep;
	end

	// ****************************************************************
	// APB access
	// ****************************************************************
	assign access = psel && penable;
	assign wrEn = access && pwrite && pready;
	assign mapped = paddr == ADDR_SEL || paddr == ADDR_FLAGS
		|| paddr == ADDR_WDOG || paddr == ADDR_STAT
		|| paddr == ADDR_IRQ_STAT || paddr == ADDR_IRQ_MASK;

	always_comb
	begin
		rdData = '0;
		case (paddr)
			ADDR_SEL:
				rdData[7:0] = selCode_r;
			ADDR_FLAGS:
				rdData[FLAG_W-1:0] = flags_r;
			ADDR_WDOG:
				rdData[7:0] = wdogCtrl_r;
			ADDR_STAT:
			begin
				rdData[STAT_TO] = timeoutStatusFlag;
				rdData[STAT_PDF] = powerdownStatusFlag;
				rdData[STAT_BUSY] = coreResetReq;
			end
			ADDR_IRQ_STAT:
				rdData[IRQ_W-1:0] = irqStat;
			ADDR_IRQ_MASK:
				rdData[IRQ_W-1:0] = irqMask;
			default:
				rdData = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			pready <= 1'b0;
		else if (clkEn)
			pready <= access && !pready;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			prdata <= '0;
			pslverr <= 1'b0;
		end
		else if (clkEn)
		begin
			prdata <= (access && !pready && !pwrite) ? rdData : '0;
			pslverr <= access && !pready && !mapped;
		end
	end

	// ****************************************************************
	// Threshold select and watchdog control registers
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
			selCode_r <= SEL_RESET;
		else if (clkEn)
		begin
			if (selDone || toRun)
				selCode_r <= SEL_RESET;
			else if (lvDone)
				selCode_r <= selCode_r;
			else if (wrEn && paddr == ADDR_SEL)
				selCode_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			wdogCtrl_r <= WDOG_RESET;
		else if (clkEn)
		begin
			if (wdDone || toRun)
				wdogCtrl_r <= WDOG_RESET;
			else if (wrEn && paddr == ADDR_WDOG)
				wdogCtrl_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			lvDetectEnable <= 1'b0;
			wdogEnable <= 1'b0;
			wdogPeriodSel <= '0;
		end
		else if (clkEn)
		begin
			lvDetectEnable <= selCode_r == SEL_CODE_21V && !sleepy;
			wdogEnable <= wdogCode == WDOG_CODE_ON;
			wdogPeriodSel <= wdogCtrl_r[2:0];
		end
	end

	// ****************************************************************
	// Reset cause flags
	// ****************************************************************
	always_comb
	begin
		flagSet = '0;
		flagSet[FLAG_LV] = lvDone;
		flagSet[FLAG_SEL] = selCorrupt;
		flagSet[FLAG_WDOG] = wdDone;
		flags_nxt = flags_r;
		if (wrEn && paddr == ADDR_FLAGS)
			flags_nxt = flags_r & pwdata[FLAG_W-1:0];
		flags_nxt = flags_nxt | flagSet;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			flags_r <= FLAGS_RESET;
		else if (clkEn)
			flags_r <= flags_nxt;
	end

	// ****************************************************************
	// Time-out and power-down status
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			timeoutStatusFlag <= 1'b0;
			powerdownStatusFlag <= 1'b0;
		end
		else if (clkEn)
		begin
			if (toSleep)
			begin
				timeoutStatusFlag <= 1'b1;
				powerdownStatusFlag <= 1'b1;
			end
			else if (toRun)
				timeoutStatusFlag <= 1'b1;
			else if (fullReq)
				timeoutStatusFlag <= timeoutStatusFlag;
			else if (clrWdtInsn)
			begin
				timeoutStatusFlag <= 1'b0;
				powerdownStatusFlag <= 1'b0;
			end
			else if (haltEntry)
			begin
				timeoutStatusFlag <= 1'b0;
				powerdownStatusFlag <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// Interrupts
	// ****************************************************************
	always_comb
	begin
		irqEvents = '0;
		irqEvents[EV_LV] = lvDone;
		irqEvents[EV_SEL] = selDone;
		irqEvents[EV_WDOG] = wdDone;
		irqEvents[EV_TO_RUN] = toRun;
		irqEvents[EV_TO_SLEEP] = toSleep;
	end

	irq_status #(
		.W(IRQ_W)
	) irqRegs (
		.clk(clk),
		.rst_b(rst_b),
		.clkEn(clkEn),
		.events(irqEvents),
		.clrWr(wrEn && paddr == ADDR_IRQ_STAT),
		.maskWr(wrEn && paddr == ADDR_IRQ_MASK),
		.wrData(pwdata[IRQ_W-1:0]),
		.status(irqStat),
		.mask(irqMask),
		.irq(irq)
	);
endmodule

// file: core/rst_cause_pkg.sv
// Purpose: Shared constants of the reset-source and cause-flag logic
// Assumes: 32-bit APB register words, byte addresses below
// Notes: Tick counts are in low-speed oscillator ticks
package rst_cause_pkg;
	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam logic [7:0] ADDR_SEL = 8'h00;
	localparam logic [7:0] ADDR_FLAGS = 8'h04;
	localparam logic [7:0] ADDR_WDOG = 8'h08;
	localparam logic [7:0] ADDR_STAT = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	// ****************************************************************
	// Codes and reset values
	// ****************************************************************
	localparam logic [7:0] SEL_CODE_21V = 8'h5A;
	localparam logic [7:0] SEL_CODE_OFF = 8'hA5;
	localparam logic [7:0] SEL_RESET = 8'h5A;
	localparam logic [4:0] WDOG_CODE_OFF = 5'h15;
	localparam logic [4:0] WDOG_CODE_ON = 5'h0A;
	localparam logic [7:0] WDOG_RESET = 8'h53;
	localparam int WDOG_CODE_LSB = 3;
	localparam logic [2:0] FLAGS_RESET = 3'h0;
	// ****************************************************************
	// Field positions
	// ****************************************************************
	localparam int FLAG_W = 3;
	localparam int FLAG_WDOG = 0;
	localparam int FLAG_SEL = 1;
	localparam int FLAG_LV = 2;
	localparam int STAT_TO = 0;
	localparam int STAT_PDF = 1;
	localparam int STAT_BUSY = 2;
	localparam int IRQ_W = 5;
	localparam int EV_LV = 0;
	localparam int EV_SEL = 1;
	localparam int EV_WDOG = 2;
	localparam int EV_TO_RUN = 3;
	localparam int EV_TO_SLEEP = 4;
	// ****************************************************************
	// Power modes
	// ****************************************************************
	localparam logic [1:0] MODE_FAST = 2'h0;
	localparam logic [1:0] MODE_SLOW = 2'h1;
	localparam logic [1:0] MODE_IDLE = 2'h2;
	localparam logic [1:0] MODE_SLEEP = 2'h3;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int SW_RESET_TICKS = 8;
	localparam int LV_PERSIST_TICKS = 4;
	localparam int RST_HOLD_CYCLES = 4;
endpackage

// file: verif/reset_source_and_flag_control_properties.sv
// Purpose: Port-level checks of the reset-source block
// Assumes: clkEn held high
// Notes: Bound to the top module
`timescale 1ns/1ps
module reset_source_and_flag_control_properties
	import rst_cause_pkg::*;
#(
	parameter int HOLD_CYCLES = 4
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB
	input wire logic [7:0] paddr,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Sources
	input wire logic wdogTimeout,
	input wire logic [1:0] powerMode,
	input wire logic haltEntry,
	input wire logic clrWdtInsn,
	// Outputs
	input wire logic coreResetReq,
	input wire logic wdogRestart,
	input wire logic pcSpClear,
	input wire logic lvDetectEnable,
	input wire logic timeoutStatusFlag,
	input wire logic powerdownStatusFlag
);
	// ********
	// Checks
	// ********
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic run;
	assign run = powerMode inside {MODE_FAST, MODE_SLOW};
	sequence s_tmo_run;
		wdogTimeout && run && !coreResetReq;
	endsequence
	sequence s_tmo_sleep;
		wdogTimeout && !run && !coreResetReq;
	endsequence
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("pready held too long");
	property p_err_zero;
		pready && pslverr |-> prdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero)
		else $error("error read not zero");
	property p_flags_hi;
		pready && !pwrite && paddr == ADDR_FLAGS |-> prdata[31:3] == 29'h0;
	endproperty
	a_flags_hi: assert property (p_flags_hi)
		else $error("flag upper bits set");
	property p_tmo_run;
		s_tmo_run |=> coreResetReq && timeoutStatusFlag &&
			powerdownStatusFlag == $past(powerdownStatusFlag);
	endproperty
	a_tmo_run: assert property (p_tmo_run)
		else $error("running time-out wrong");
	property p_tmo_sleep;
		s_tmo_sleep |=> pcSpClear && timeoutStatusFlag &&
			powerdownStatusFlag && !coreResetReq;
	endproperty
	a_tmo_sleep: assert property (p_tmo_sleep)
		else $error("sleeping time-out wrong");
	property p_restart;
		$fell(coreResetReq) |-> ##[0:1] wdogRestart;
	endproperty
	a_restart: assert property (p_restart)
		else $error("no watchdog restart");
	property p_hold;
		$rose(coreResetReq) |-> coreResetReq [*4];
	endproperty
	a_hold: assert property (p_hold)
		else $error("reset hold short");
	property p_lv_off;
		!run ##1 !run |-> !lvDetectEnable;
	endproperty
	a_lv_off: assert property (p_lv_off)
		else $error("detection on in idle or sleep");
	property p_to_keep;
		timeoutStatusFlag && !clrWdtInsn && !haltEntry |=> timeoutStatusFlag;
	endproperty
	a_to_keep: assert property (p_to_keep)
		else $error("time-out flag lost");
endmodule
bind reset_source_and_flag_control
	reset_source_and_flag_control_properties
	#(.HOLD_CYCLES(HOLD_CYCLES)) props_i (
	.clk(clk), .rst_b(rst_b), .paddr(paddr), .pwrite(pwrite),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.wdogTimeout(wdogTimeout), .powerMode(powerMode),
	.haltEntry(haltEntry), .clrWdtInsn(clrWdtInsn),
	.coreResetReq(coreResetReq), .wdogRestart(wdogRestart),
	.pcSpClear(pcSpClear), .lvDetectEnable(lvDetectEnable),
	.timeoutStatusFlag(timeoutStatusFlag),
	.powerdownStatusFlag(powerdownStatusFlag));

// file: verif/tb_reset_source_and_flag_control.sv
// Purpose: Self-checking bench of the reset-source block
// Assumes: Small tick counts, clkEn held high
// Notes: Random codes from a fixed xorshift seed
`timescale 1ns/1ps
module tb_reset_source_and_flag_control
	import rst_cause_pkg::*;
();
	localparam int SW_T = 8;
	localparam int LV_T = 4;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic clkEn = 1'b1;
	logic [7:0] paddr = 8'h00;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic lircTick = 1'b0;
	logic lowVoltage = 1'b0;
	logic wdogTimeout = 1'b0;
	logic [1:0] powerMode = MODE_FAST;
	logic haltEntry = 1'b0;
	logic clrWdtInsn = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, coreResetReq, wdogRestart, pcSpClear;
	logic lvDetectEnable, wdogEnable, irq, toFlag, pdFlag;
	logic [2:0] wdogPeriodSel;
	logic [31:0] rd;
	logic [31:0] seed = 32'h26;
	logic er;
	logic [7:0] code;
	logic [2:0] per;
	int errors = 0;
	int testsRun = 0;
	int cycles = 0;
	reset_source_and_flag_control #(.SW_TICKS(SW_T), .LV_TICKS(LV_T),
		.HOLD_CYCLES(4)) reset_source_and_flag_control_i (
		.clk(clk), .rst_b(rst_b), .clkEn(clkEn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.lircTick(lircTick), .lowVoltage(lowVoltage),
		.wdogTimeout(wdogTimeout), .powerMode(powerMode),
		.haltEntry(haltEntry), .clrWdtInsn(clrWdtInsn),
		.coreResetReq(coreResetReq), .wdogRestart(wdogRestart),
		.pcSpClear(pcSpClear), .lvDetectEnable(lvDetectEnable),
		.wdogEnable(wdogEnable), .wdogPeriodSel(wdogPeriodSel),
		.timeoutStatusFlag(toFlag), .powerdownStatusFlag(pdFlag),
		.irq(irq));
	// ********
	// Helpers
	// ********
	always #2 clk = ~clk;
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			errors++;
			tally_and_finish();
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic expLvEn(input logic [7:0] c,
		input logic [1:0] m);
		return c == SEL_CODE_21V && (m == MODE_FAST || m == MODE_SLOW);
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	task automatic ticks(input int k);
		repeat (k)
		begin
			lircTick <= 1'b1;
			@(posedge clk);
			lircTick <= 1'b0;
			repeat (2) @(posedge clk);
		end
	endtask
	task automatic pulse(input int w);
		case (w)
			0: wdogTimeout <= 1'b1;
			1: haltEntry <= 1'b1;
			default: clrWdtInsn <= 1'b1;
		endcase
		@(posedge clk);
		wdogTimeout <= 1'b0;
		haltEntry <= 1'b0;
		clrWdtInsn <= 1'b0;
		@(posedge clk);
	endtask
	task automatic waitRst(input logic exp);
		int n;
		n = 0;
		while (coreResetReq !== 1'b1 && n < 20)
		begin
			@(posedge clk);
			n++;
		end
		chk(coreResetReq, exp);
		while (coreResetReq !== 1'b0 && n < 80)
		begin
			@(posedge clk);
			n++;
		end
		repeat (3) @(posedge clk);
	endtask
	task automatic tally_and_finish();
		$display("errors=%0d testsRun=%0d", errors, testsRun);
		if (errors == 0 && testsRun > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// ********
	// Scenarios
	// ********
	initial
	begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		waitRst(1'b1);
		rdchk(ADDR_SEL, 32'h5A);
		rdchk(ADDR_FLAGS, 32'h0);
		rdchk(ADDR_WDOG, 32'h53);
		rdchk(ADDR_STAT, 32'h0);
		apb(1'b0, 8'h18, 32'h0);
		chk(er, 1'b1);
		for (int i = 0; i < 8; i++)
		begin
			code = i[0] ? SEL_CODE_OFF : SEL_CODE_21V;
			apb(1'b1, ADDR_SEL, {24'h0, code});
			powerMode <= i[2:1];
			repeat (3) @(posedge clk);
			chk(lvDetectEnable, expLvEn(code, i[2:1]));
		end
		apb(1'b1, ADDR_SEL, 32'h5A);
		lowVoltage <= 1'b1;
		ticks(8);
		waitRst(1'b0);
		powerMode <= MODE_FAST;
		repeat (3) @(posedge clk);
		ticks(LV_T);
		waitRst(1'b0);
		ticks(1);
		waitRst(1'b1);
		lowVoltage <= 1'b0;
		rdchk(ADDR_FLAGS, 32'h4);
		rdchk(ADDR_SEL, 32'h5A);
		apb(1'b1, ADDR_FLAGS, 32'hFF);
		rdchk(ADDR_FLAGS, 32'h4);
		apb(1'b1, ADDR_FLAGS, 32'h0);
		rdchk(ADDR_FLAGS, 32'h0);
		code = 8'(rnd());
		while (code == SEL_CODE_21V || code == SEL_CODE_OFF)
			code = 8'(rnd());
		apb(1'b1, ADDR_SEL, {24'h0, code});
		rdchk(ADDR_FLAGS, 32'h2);
		ticks(SW_T - 1);
		waitRst(1'b0);
		ticks(1);
		waitRst(1'b1);
		rdchk(ADDR_SEL, 32'h5A);
		rdchk(ADDR_FLAGS, 32'h2);
		apb(1'b1, ADDR_FLAGS, 32'h0);
		per = 3'(rnd());
		apb(1'b1, ADDR_WDOG, {24'h0, WDOG_CODE_OFF, per});
		@(posedge clk);
		chk(wdogEnable, 1'b0);
		chk(wdogPeriodSel, per);
		apb(1'b1, ADDR_WDOG, {24'h0, WDOG_CODE_ON, ~per});
		@(posedge clk);
		chk(wdogEnable, 1'b1);
		chk(wdogPeriodSel, 3'(~per));
		apb(1'b1, ADDR_WDOG, {24'h0, 5'h1F, per});
		ticks(SW_T);
		waitRst(1'b1);
		rdchk(ADDR_FLAGS, 32'h1);
		apb(1'b1, ADDR_FLAGS, 32'h0);
		apb(1'b1, ADDR_WDOG, 32'h53);
		apb(1'b1, ADDR_IRQ_STAT, 32'h1F);
		rdchk(ADDR_IRQ_STAT, 32'h0);
		apb(1'b1, ADDR_IRQ_MASK, 32'h08);
		apb(1'b1, ADDR_SEL, 32'hA5);
		pulse(1);
		chk({toFlag, pdFlag}, 2'b01);
		powerMode <= MODE_SLEEP;
		pulse(0);
		chk({pcSpClear, coreResetReq}, 2'b10);
		chk({toFlag, pdFlag}, 2'b11);
		rdchk(ADDR_SEL, 32'hA5);
		rdchk(ADDR_IRQ_STAT, 32'h10);
		chk(irq, 1'b0);
		pulse(2);
		chk({toFlag, pdFlag}, 2'b00);
		powerMode <= MODE_FAST;
		pulse(0);
		chk(coreResetReq, 1'b1);
		waitRst(1'b1);
		chk({toFlag, pdFlag}, 2'b10);
		rdchk(ADDR_SEL, 32'h5A);
		rdchk(ADDR_WDOG, 32'h53);
		chk(irq, 1'b1);
		apb(1'b1, ADDR_IRQ_STAT, 32'h08);
		repeat (2) @(posedge clk);
		chk(irq, 1'b0);
		rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		waitRst(1'b1);
		rdchk(ADDR_STAT, 32'h0);
		tally_and_finish();
	end
endmodule
